//--- core/serializer_config_regs.sv
// What this block does
// - Address register reports seven-bit target id in use
// - Override bit gates target id writes
// - Bit two triggers ROM reload, self-clears
// - Bit one resets logic and registers
// - Bit zero resets logic, keeps registers
// - Bit six selects continuous clock lane
// - Bits five:four select lane count
// - Bit one enables transmit CRC generator
// - Voltage level loaded from strap, writable
// - Mode override selects strap or register
// - Read-only bit reports mode captured
// - Mode field writable only under override
// - Strap mode captured on power-down release
// - Mode field decodes documented operating modes
//
// First four configuration registers of the serializer, on a byte register port.
// Assumes an I2C target front end drives the byte port on sys_clk_in; pins are async.
`timescale 1ns/1ns
`include "serializer_config_params.svh"
module serializer_config_regs
  import serializer_config_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic power_down_pin_n_in,
  input wire logic [6:0] target_id_strap_in,
  input wire logic address_strap_pin_in,
  input wire logic [2:0] mode_strap_in,
  input wire logic mode_strap_rsvd_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [6:0] i2c_target_id_out,
  output logic rom_reload_out,
  output logic logic_reset_out,
  output logic clock_lane_continuous_out,
  output logic [1:0] lane_count_out,
  output logic crc_tx_enable_out,
  output logic i2c_voltage_1v8_out,
  output logic [2:0] op_mode_out,
  output logic mode_settled_out,
  output logic sync_camera_mode_out,
  output logic nonsync_ext_clk_mode_out,
  output logic always_on_oscillator_out,
  output logic parallel_video_port_out
);
  logic [12:0] pins_sync;
  logic pdb_s;
  logic pdb_prev_r;
  logic [6:0] strap_id_s;
  logic idx_s;
  logic [2:0] strap_mode_s;
  logic rsvd_s;
  logic pdb_rise;
  logic [1:0] start_cnt_r;
  logic full_reset_r;
  logic regs_rst;
  logic wr_addr;
  logic wr_reset_control;
  logic wr_general;
  logic wr_mode;
  logic target_id_override_r;
  logic [6:0] target_id_r;
  logic [4:0] reset_control_rsvd_r;
  logic gen_rsvd7_r;
  logic [1:0] gen_rsvd32_r;
  logic clock_lane_continuous_r;
  logic [1:0] lane_count_r;
  logic crc_tx_enable_r;
  logic i2c_voltage_r;
  logic mode_rsvd7_r;
  logic mode_rsvd5_r;
  logic mode_strap_rsvd_r;
  logic mode_override_r;
  logic mode_settled_r;
  logic [2:0] strap_mode_r;
  logic [2:0] mode_reg_r;
  logic [3:0] logic_reset_cnt_r;
  logic rom_reload_r;
  logic [6:0] id_in_use;
  logic [2:0] mode_in_use;
  reg_byte_t rdata_nxt;

  function automatic logic is_mode(input logic [2:0] cur, input op_mode_e m);
    return cur == m;
  endfunction

  function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  strap_sync #(.WIDTH(13)) u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .async_in({power_down_pin_n_in, target_id_strap_in, address_strap_pin_in,
               mode_strap_in, mode_strap_rsvd_in}),
    .sync_out(pins_sync)
  );
  assign {pdb_s, strap_id_s, idx_s, strap_mode_s, rsvd_s} = pins_sync;

  // Register contents reset by pin reset or the full-reset trigger
  assign regs_rst = srst_in | full_reset_r;

  assign wr_addr = reg_wr_in && hits(reg_addr_in, `OFS_I2C_ADDRESS_CONFIG);
  assign wr_reset_control = reg_wr_in && hits(reg_addr_in, `OFS_RESET_CONTROL);
  assign wr_general = reg_wr_in && hits(reg_addr_in, `OFS_GENERAL_CONFIG);
  assign wr_mode = reg_wr_in && hits(reg_addr_in, `OFS_OPERATING_MODE_SELECT);

  assign id_in_use = target_id_override_r ? target_id_r : strap_id_s;
  assign mode_in_use = mode_override_r ? mode_reg_r : strap_mode_r;

  // Start-up strap loads span the synchroniser latency
  // Last load sees the pins through both flops
  always_ff @(posedge sys_clk_in) begin
    if (regs_rst) begin
      start_cnt_r <= 2'h0;
    end else if (start_cnt_r != `STARTUP_LOAD_CYCLES) begin
      start_cnt_r <= start_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      full_reset_r <= 1'b0;
    end else begin
      full_reset_r <= wr_reset_control && reg_wdata_in[`BIT_FULL_RESET] && !full_reset_r;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (regs_rst) begin
      logic_reset_cnt_r <= 4'h0;
    end else if (wr_reset_control && reg_wdata_in[`BIT_LOGIC_RESET]) begin
      logic_reset_cnt_r <= `LOGIC_RESET_CYCLES;
    end else if (logic_reset_cnt_r != 4'h0) begin
      logic_reset_cnt_r <= logic_reset_cnt_r - 4'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (regs_rst) begin
      rom_reload_r <= 1'b0;
    end else begin
      rom_reload_r <= wr_reset_control && reg_wdata_in[`BIT_ROM_RELOAD_TRIGGER];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (regs_rst) begin
      reset_control_rsvd_r <= 5'h00;
    end else if (wr_reset_control) begin
      reset_control_rsvd_r <= reg_wdata_in[7:3];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (regs_rst) begin
      target_id_override_r <= 1'b0;
      target_id_r <= 7'h00;
    end else if (wr_addr) begin
      target_id_override_r <= reg_wdata_in[`BIT_TARGET_ID_OVERRIDE];
      if (target_id_override_r || reg_wdata_in[`BIT_TARGET_ID_OVERRIDE]) begin
        target_id_r <= target_id_override_r ? reg_wdata_in[7:1] : strap_id_s;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (regs_rst) begin
      clock_lane_continuous_r <= `RST_CLOCK_LANE_CONTINUOUS;
      lane_count_r <= `RST_LANE_COUNT;
      crc_tx_enable_r <= `RST_CRC_TX_ENABLE;
    end else if (wr_general) begin
      clock_lane_continuous_r <= reg_wdata_in[`BIT_CLOCK_LANE_CONTINUOUS];
      lane_count_r <= reg_wdata_in[`BIT_LANE_COUNT_LO +: 2];
      crc_tx_enable_r <= reg_wdata_in[`BIT_CRC_TX_ENABLE];
    end
  end

  // Reserved general bits keep what is written
  always_ff @(posedge sys_clk_in) begin
    if (regs_rst) begin
      gen_rsvd7_r <= 1'b0;
      gen_rsvd32_r <= 2'h0;
    end else if (wr_general) begin
      gen_rsvd7_r <= reg_wdata_in[7];
      gen_rsvd32_r <= reg_wdata_in[3:2];
    end
  end

  // Voltage level from strap, then writable
  always_ff @(posedge sys_clk_in) begin
    if (regs_rst) begin
      i2c_voltage_r <= 1'b0;
    end else if (start_cnt_r != `STARTUP_LOAD_CYCLES) begin
      i2c_voltage_r <= idx_s;
    end else if (wr_general) begin
      i2c_voltage_r <= reg_wdata_in[`BIT_I2C_VOLTAGE_LEVEL];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      pdb_prev_r <= 1'b0;
    end else begin
      pdb_prev_r <= pdb_s;
    end
  end
  assign pdb_rise = pdb_s && !pdb_prev_r;

  // Capture strap mode on power-down release
  always_ff @(posedge sys_clk_in) begin
    if (regs_rst) begin
      strap_mode_r <= `RST_MODE_FIELD;
      mode_strap_rsvd_r <= 1'b0;
    end else if (pdb_rise) begin
      strap_mode_r <= strap_mode_s;
      mode_strap_rsvd_r <= rsvd_s;
    end
  end

  // Mode captured flag, dropped while powered down
  always_ff @(posedge sys_clk_in) begin
    if (regs_rst) begin
      mode_settled_r <= 1'b0;
    end else if (pdb_rise) begin
      mode_settled_r <= 1'b1;
    end else if (!pdb_s) begin
      mode_settled_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (regs_rst) begin
      mode_rsvd7_r <= 1'b0;
      mode_rsvd5_r <= 1'b0;
      mode_override_r <= 1'b0;
      mode_reg_r <= `RST_MODE_FIELD;
    end else if (wr_mode) begin
      mode_rsvd7_r <= reg_wdata_in[7];
      mode_rsvd5_r <= reg_wdata_in[5];
      mode_override_r <= reg_wdata_in[`BIT_MODE_OVERRIDE];
      mode_reg_r <= mode_override_r ? reg_wdata_in[2:0] : mode_in_use;
    end else if (!mode_override_r) begin
      mode_reg_r <= strap_mode_r;
    end
  end

  always_comb begin
    rdata_nxt = `RST_RESERVED_BYTE;
    if (hits(reg_addr_in, `OFS_I2C_ADDRESS_CONFIG)) begin
      rdata_nxt = {id_in_use, target_id_override_r};
    end else if (hits(reg_addr_in, `OFS_RESET_CONTROL)) begin
      rdata_nxt = {reset_control_rsvd_r, 3'h0};
    end else if (hits(reg_addr_in, `OFS_GENERAL_CONFIG)) begin
      rdata_nxt = {gen_rsvd7_r, clock_lane_continuous_r, lane_count_r, gen_rsvd32_r,
                   crc_tx_enable_r, i2c_voltage_r};
    end else if (hits(reg_addr_in, `OFS_OPERATING_MODE_SELECT)) begin
      rdata_nxt = {mode_rsvd7_r, mode_strap_rsvd_r, mode_rsvd5_r, mode_override_r,
                   mode_settled_r, mode_in_use};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_nxt;
      end
    end
  end

  // Address in use and trigger pulses
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      i2c_target_id_out <= 7'h00;
      rom_reload_out <= 1'b0;
      logic_reset_out <= 1'b0;
    end else begin
      i2c_target_id_out <= id_in_use;
      rom_reload_out <= rom_reload_r;
      logic_reset_out <= (logic_reset_cnt_r != 4'h0) || full_reset_r;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      clock_lane_continuous_out <= `RST_CLOCK_LANE_CONTINUOUS;
      lane_count_out <= `RST_LANE_COUNT;
      crc_tx_enable_out <= `RST_CRC_TX_ENABLE;
      i2c_voltage_1v8_out <= 1'b0;
    end else begin
      clock_lane_continuous_out <= clock_lane_continuous_r;
      lane_count_out <= lane_count_r;
      crc_tx_enable_out <= crc_tx_enable_r;
      i2c_voltage_1v8_out <= i2c_voltage_r;
    end
  end

  // Mode in use and settled flag
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      op_mode_out <= `RST_MODE_FIELD;
      mode_settled_out <= 1'b0;
    end else begin
      op_mode_out <= mode_in_use;
      mode_settled_out <= mode_settled_r;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sync_camera_mode_out <= 1'b0;
      nonsync_ext_clk_mode_out <= 1'b0;
      always_on_oscillator_out <= 1'b0;
      parallel_video_port_out <= 1'b0;
    end else begin
      sync_camera_mode_out <= is_mode(mode_in_use, MODE_SYNC_CAMERA);
      nonsync_ext_clk_mode_out <= is_mode(mode_in_use, MODE_NONSYNC_EXT_CLK);
      always_on_oscillator_out <= is_mode(mode_in_use, MODE_NONSYNC_ALWAYS_ON);
      parallel_video_port_out <= is_mode(mode_in_use, MODE_PARALLEL_VIDEO_PORT);
    end
  end
endmodule // serializer_config_regs

//--- core/serializer_config_params.svh
// Offsets, field positions, reset values and timing counts of the configuration bank.
// Included by the register module only; definitions only.
`ifndef SERIALIZER_CONFIG_PARAMS_SVH
`define SERIALIZER_CONFIG_PARAMS_SVH

`define OFS_I2C_ADDRESS_CONFIG 8'h00
`define OFS_RESET_CONTROL 8'h01
`define OFS_GENERAL_CONFIG 8'h02
`define OFS_OPERATING_MODE_SELECT 8'h03

`define BIT_TARGET_ID_OVERRIDE 0
`define BIT_ROM_RELOAD_TRIGGER 2
`define BIT_FULL_RESET 1
`define BIT_LOGIC_RESET 0
`define BIT_CLOCK_LANE_CONTINUOUS 6
`define BIT_LANE_COUNT_LO 4
`define BIT_CRC_TX_ENABLE 1
`define BIT_I2C_VOLTAGE_LEVEL 0
`define BIT_MODE_OVERRIDE 4
`define BIT_MODE_SETTLED 3
`define BIT_MODE_STRAP_RSVD 6

`define RST_CLOCK_LANE_CONTINUOUS 1'h0
`define RST_LANE_COUNT 2'h3
`define RST_CRC_TX_ENABLE 1'h1
`define RST_RESERVED_BYTE 8'h00
`define RST_MODE_FIELD 3'h0

// Cycles a logic-reset pulse is held after a trigger
`define LOGIC_RESET_CYCLES 4'h4

// Start-up strap load cycles, covering the two-flop pin latency
`define STARTUP_LOAD_CYCLES 2'h3

`endif

//--- core/serializer_config_pkg.sv
// Types shared by the configuration bank.
// Assumes the params header sits beside it.
package serializer_config_pkg;
  typedef enum logic [2:0] {
    MODE_SYNC_CAMERA = 3'h0,
    MODE_RESERVED_1 = 3'h1,
    MODE_NONSYNC_EXT_CLK = 3'h2,
    MODE_NONSYNC_ALWAYS_ON = 3'h3,
    MODE_RESERVED_4 = 3'h4,
    MODE_PARALLEL_VIDEO_PORT = 3'h5,
    MODE_RESERVED_6 = 3'h6,
    MODE_RESERVED_7 = 3'h7
  } op_mode_e;

  typedef enum logic [1:0] {
    LANES_ONE = 2'h0,
    LANES_TWO = 2'h1,
    LANES_UNDEFINED = 2'h2,
    LANES_FOUR = 2'h3
  } lane_count_e;

  typedef logic [7:0] reg_byte_t;
endpackage

//--- core/strap_sync.sv
// Two-flop synchroniser for pin-level straps and the power-down pin.
// Assumes inputs are asynchronous to sys_clk_in.
`timescale 1ns/1ns
module strap_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // strap_sync

//--- tb/serializer_config_regs_chk.sv
// Port checker for the configuration bank.
// Bound to serializer_config_regs; one clock, synchronous reset.
`timescale 1ns/1ns
module serializer_config_regs_chk (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic rom_reload_out,
  input wire logic logic_reset_out,
  input wire logic [1:0] lane_count_out,
  input wire logic crc_tx_enable_out
);
  wire logic wr_rst = reg_wr_in && reg_addr_in == 8'h01;
  wire logic wr_gen = reg_wr_in && reg_addr_in == 8'h02;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  stray_valid_a: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("valid without read");
  reload_pulse_a: assert property (
    wr_rst && reg_wdata_in[2:1] == 2'b10 |-> ##2 rom_reload_out ##1 !rom_reload_out
  ) else $error("reload pulse wrong");
  trigger_zero_a: assert property (
    reg_rd_in && reg_addr_in == 8'h01 |=> reg_rdata_out[2:0] == 3'h0
  ) else $error("trigger bits read back");
  unmapped_zero_a: assert property (
    reg_rd_in && reg_addr_in > 8'h03 |=> reg_rdata_out == 8'h00
  ) else $error("unmapped read not zero");
  logic_reset_hold_a: assert property (
    wr_rst && reg_wdata_in[1:0] == 2'b01 |-> ##2 logic_reset_out [*4] ##1 !logic_reset_out
  ) else $error("logic reset length wrong");
  lane_write_a: assert property (
    wr_gen |-> ##2 lane_count_out == $past(reg_wdata_in[5:4], 2)
  ) else $error("lane count not written");
  crc_write_a: assert property (
    wr_gen |-> ##2 crc_tx_enable_out == $past(reg_wdata_in[1], 2)
  ) else $error("crc enable not written");
endmodule // serializer_config_regs_chk

bind serializer_config_regs serializer_config_regs_chk chk_u (
  .sys_clk_in, .srst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
  .reg_rvalid_out, .rom_reload_out, .logic_reset_out, .lane_count_out, .crc_tx_enable_out
);

//--- tb/cfg_host_model.sv
// Host on the byte register port, standing in for the I2C front end.
// Drives at falling edges; a released bus shows inverted values.
`timescale 1ns/1ns
module cfg_host_model (
  input wire logic sys_clk_in,
  input wire logic reg_rvalid_out,
  input wire logic [7:0] reg_rdata_out,
  output logic reg_wr_in,
  output logic reg_rd_in,
  output logic [7:0] reg_addr_in,
  output logic [7:0] reg_wdata_in
);
  initial begin
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge sys_clk_in);
    reg_wr_in = 1'b0;
    reg_addr_in = ~a;
    reg_wdata_in = ~d;
    @(negedge sys_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge sys_clk_in);
    reg_rd_in = 1'b0;
    reg_addr_in = ~a;
    d = (reg_rvalid_out === 1'b1) ? reg_rdata_out : 8'hXX;
  endtask
endmodule // cfg_host_model

//--- tb/serializer_config_regs_test.sv
// Bench for the configuration bank: straps and pin driven here, byte port by the host model.
// Assumes outputs settle one cycle after a write takes effect.
`timescale 1ns/1ns
module serializer_config_regs_test;
  logic sys_clk_in = 1'b0, srst_in = 1'b1, power_down_pin_n_in = 1'b0;
  logic address_strap_pin_in = 1'b1, mode_strap_rsvd_in = 1'b1;
  logic [6:0] target_id_strap_in = 7'h2A, i2c_target_id_out;
  logic [2:0] mode_strap_in = 3'h3, op_mode_out;
  logic reg_wr_in, reg_rd_in, reg_rvalid_out, rom_reload_out, logic_reset_out, mode_settled_out;
  logic clock_lane_continuous_out, crc_tx_enable_out, i2c_voltage_1v8_out, sync_camera_mode_out;
  logic nonsync_ext_clk_mode_out, always_on_oscillator_out, parallel_video_port_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [1:0] lane_count_out;
  int n_fail = 0, tests_run = 0;
  wire logic [3:0] decodes = {sync_camera_mode_out, nonsync_ext_clk_mode_out,
    always_on_oscillator_out, parallel_video_port_out};
  wire logic [7:0] cfg_pins = {1'b0, clock_lane_continuous_out, lane_count_out, 2'h0,
    crc_tx_enable_out, i2c_voltage_1v8_out};
  always #20 sys_clk_in = ~sys_clk_in;
  serializer_config_regs dut_u (
    .sys_clk_in, .srst_in, .power_down_pin_n_in, .target_id_strap_in, .address_strap_pin_in,
    .mode_strap_in, .mode_strap_rsvd_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .reg_rvalid_out, .i2c_target_id_out, .rom_reload_out, .logic_reset_out,
    .clock_lane_continuous_out, .lane_count_out, .crc_tx_enable_out, .i2c_voltage_1v8_out,
    .op_mode_out, .mode_settled_out, .sync_camera_mode_out, .nonsync_ext_clk_mode_out,
    .always_on_oscillator_out, .parallel_video_port_out
  );
  cfg_host_model host_u (.sys_clk_in, .reg_rvalid_out, .reg_rdata_out, .reg_wr_in, .reg_rd_in,
    .reg_addr_in, .reg_wdata_in);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, exp);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic t_pin_cycle();
    power_down_pin_n_in = 1'b0;
    repeat (8) @(negedge sys_clk_in);
    chk({7'h00, mode_settled_out}, 8'h00);
    power_down_pin_n_in = 1'b1;
    repeat (6) @(negedge sys_clk_in);
    chk({4'h0, mode_settled_out, op_mode_out}, 8'h0B);
    rd_chk(8'h00, 8'h54);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h02, 8'h33);
    rd_chk(8'h03, 8'h4B);
  endtask
  task automatic t_target_id();
    host_u.wr(8'h00, 8'hAA);
    chk({1'b0, i2c_target_id_out}, 8'h2A);
    rd_chk(8'h00, 8'h54);
    host_u.wr(8'h00, 8'hAB);
    chk({1'b0, i2c_target_id_out}, 8'h2A);
    rd_chk(8'h00, 8'h55);
    host_u.wr(8'h00, 8'hAB);
    chk({1'b0, i2c_target_id_out}, 8'h55);
    rd_chk(8'h00, 8'hAB);
  endtask
  task automatic t_general();
    // Voltage bit kept at strap level, lane code two unused
    logic [7:0] v [4] = '{8'h41, 8'h33, 8'h03, 8'h13};
    foreach (v[i]) begin
      host_u.wr(8'h02, v[i]);
      chk(cfg_pins, v[i]);
      rd_chk(8'h02, v[i]);
    end
  endtask
  task automatic t_mode();
    logic [7:0] e [6] = '{8'h08, 8'h10, 8'h24, 8'h32, 8'h51, 8'h70};
    host_u.wr(8'h03, 8'h15);
    rd_chk(8'h03, 8'h5B);
    foreach (e[i]) begin
      host_u.wr(8'h03, {5'h02, e[i][6:4]});
      chk({1'b0, op_mode_out, decodes}, e[i]);
      rd_chk(8'h03, {5'h0B, e[i][6:4]});
    end
  endtask
  task automatic t_resets();
    host_u.wr(8'h01, 8'h04);
    chk({7'h00, rom_reload_out}, 8'h01);
    @(negedge sys_clk_in);
    chk({7'h00, rom_reload_out}, 8'h00);
    host_u.wr(8'h01, 8'h09);
    chk({7'h00, logic_reset_out}, 8'h01);
    repeat (4) @(negedge sys_clk_in);
    chk({7'h00, logic_reset_out}, 8'h00);
    rd_chk(8'h01, 8'h08);
    rd_chk(8'h00, 8'hAB);
    host_u.wr(8'h04, 8'hFF);
    rd_chk(8'h04, 8'h00);
    host_u.wr(8'h01, 8'h02);
    repeat (3) @(negedge sys_clk_in);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h00, 8'h54);
    rd_chk(8'h02, 8'h33);
    rd_chk(8'h03, 8'h00);
  endtask
  initial begin
    repeat (6) @(negedge sys_clk_in);
    srst_in = 1'b0;
    t_pin_cycle();
    t_target_id();
    t_general();
    t_mode();
    t_resets();
    t_pin_cycle();
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    n_fail++;
    finish_test();
  end
endmodule // serializer_config_regs_test
